// ===== shared/adc_ctl_defines.svh
`ifndef ADC_CTL_DEFINES_SVH
`define ADC_CTL_DEFINES_SVH

// register indices; byte address is four times the index
`define IDX_INPUT_SELECT   8'hBB
`define IDX_CONTROL        8'hBC
`define IDX_RESULT         8'hBD
`define IDX_GT_THRESHOLD   8'hBE
`define IDX_LT_THRESHOLD   8'hBF
`define IDX_STATUS         8'hC0
`define IDX_MASK           8'hC1

// reset values
`define RST_INPUT_SELECT   5'h1F
`define RST_THRESHOLD      10'h000

// input select codes
`define SEL_TEMP_SENSOR    5'h10
`define SEL_SUPPLY         5'h11
`define SEL_NONE_FIRST     5'h16

// control bits
`define CTL_SW_START       0
`define CTL_EXT_EN         1
`define CTL_OUTSIDE        2

// status and mask bits
`define ST_WINDOW          0
`define ST_CONV_DONE       1
`define ST_BUSY            2

`endif

// ===== shared/adc_ctl_pkg.sv
package adc_ctl_pkg;

	typedef enum logic {SEQ_IDLE, SEQ_WAIT} seq_state_t;

	typedef struct packed {
		seq_state_t state;
		logic       go;
		logic       done;
		logic       hit;
		logic [9:0] result;
	} seq_regs_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic [4:0]  input_select;
		logic        ext_en;
		logic        outside;
		logic        sw_start;
		logic [9:0]  gt_threshold;
		logic [9:0]  lt_threshold;
		logic [1:0]  status;
		logic [1:0]  mask;
		logic        irq;
		logic [2:0]  pin_sync;
		logic [7:0]  port0_sel;
		logic [7:0]  port1_sel;
		logic        temp_sel;
		logic        supply_sel;
	} ctl_regs_t;

endpackage : adc_ctl_pkg

// ===== verilog/conv_sequencer.sv
module conv_sequencer
	import adc_ctl_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// request and window setup
	input  wire logic       start,
	input  wire logic       outside,
	input  wire logic [9:0] gt_threshold,
	input  wire logic [9:0] lt_threshold,
	// converter handshake
	input  wire logic       conv_done,
	input  wire logic [9:0] conv_data,
	output logic            conv_go,
	// results
	output logic            busy,
	output logic            done,
	output logic            hit,
	output logic [9:0]      result
);

	seq_regs_t r_ff;
	seq_regs_t nxt_r;

	always_comb
	begin
		nxt_r      = r_ff;
		nxt_r.go   = 1'b0;
		nxt_r.done = 1'b0;
		nxt_r.hit  = 1'b0;
		unique case (r_ff.state)
			SEQ_IDLE:
			begin
				if (start)
				begin
					nxt_r.go    = 1'b1;
					nxt_r.state = SEQ_WAIT;
				end
			end
			SEQ_WAIT:
			begin
				// starts while busy are dropped, not queued
				if (conv_done)
				begin
					nxt_r.result = conv_data;
					nxt_r.done   = 1'b1;
					nxt_r.state  = SEQ_IDLE;
					// one compare per finished conversion
					if (outside)
						nxt_r.hit = (conv_data < gt_threshold) ||
							(conv_data > lt_threshold);
					else
						nxt_r.hit = (conv_data > gt_threshold) &&
							(conv_data < lt_threshold);
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			r_ff <= '{state: SEQ_IDLE, go: 1'b0, done: 1'b0, hit: 1'b0, result: 10'h000};
		else
			r_ff <= nxt_r;
	end

	assign conv_go = r_ff.go;
	assign busy    = (r_ff.state == SEQ_WAIT);
	assign done    = r_ff.done;
	assign hit     = r_ff.hit;
	assign result  = r_ff.result;

endmodule : conv_sequencer

// ===== verilog/adc_input_select_window_compare.sv
// Function
// - five-bit select picks port 0/1 pin, temperature sensor, supply, or nothing.
// - upper three select bits read zero; writes to them are dropped.
// - results are unsigned 10-bit values, zero to 1023/1024 of reference.
// - inside mode flags results strictly between the two thresholds.
// - outside mode flags results below greater-than or above less-than threshold.
// - external convert-start pin may be chosen to start conversions.
//
// Local design decision: the Wishbone slave port.
`include "adc_ctl_defines.svh"

module adc_input_select_window_compare
	import adc_ctl_pkg::*;
(
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RESETN,
	// wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [11:0] WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// converter core
	input  wire logic        CONV_DONE,
	input  wire logic [9:0]  CONV_DATA,
	output logic             CONV_START,
	// analog input mux
	output logic      [4:0]  MUX_SELECT,
	output logic      [7:0]  PORT0_SELECT,
	output logic      [7:0]  PORT1_SELECT,
	output logic             TEMP_SELECT,
	output logic             SUPPLY_SELECT,
	// external convert-start pin
	input  wire logic        EXT_CONVERT_START,
	// interrupt
	output logic             IRQ
);

	ctl_regs_t  r_ff;
	ctl_regs_t  nxt_r;
	logic       seq_go;
	logic       seq_busy;
	logic       seq_done;
	logic       seq_hit;
	logic [9:0] seq_result;
	logic       pin_rise;
	logic       seq_start;
	logic       req;
	logic       wr;
	logic       rd;
	logic       addr_ok;
	logic [7:0] idx;
	logic [9:0] gt_merge;
	logic [9:0] lt_merge;

	// byte-lane merge of a 10-bit field held in lanes 0 and 1
	function automatic logic [9:0] merge10(input logic [9:0] old_v,
		input logic [31:0] wdat, input logic [3:0] sel);
		logic [9:0] v;
		v = old_v;
		if (sel[0])
			v[7:0] = wdat[7:0];
		if (sel[1])
			v[9:8] = wdat[9:8];
		return v;
	endfunction : merge10

	// one-hot of a pin number, shared by both port decodes
	function automatic logic [7:0] onehot8(input logic [2:0] pin);
		logic [7:0] v;
		v      = 8'h00;
		v[pin] = 1'b1;
		return v;
	endfunction : onehot8

	assign req      = WB_CYC_I && WB_STB_I && !r_ff.ack;
	assign wr       = req && WB_WE_I;
	assign rd       = req && !WB_WE_I;
	assign addr_ok  = (WB_ADR_I[11:10] == 2'b00);
	assign idx      = WB_ADR_I[9:2];
	assign gt_merge = merge10(r_ff.gt_threshold, WB_DAT_I, WB_SEL_I);
	assign lt_merge = merge10(r_ff.lt_threshold, WB_DAT_I, WB_SEL_I);

	// pin_sync[0] feeds only pin_sync[1]; edge taken from stages 1 and 2
	assign pin_rise = r_ff.pin_sync[1] && !r_ff.pin_sync[2];
	// a pin edge while the pin start is disabled is lost, not held
	assign seq_start = r_ff.sw_start || (r_ff.ext_en && pin_rise);

	conv_sequencer u_seq (
		.clk          (CLK),
		.rst_n        (RESETN),
		.start        (seq_start),
		.outside      (r_ff.outside),
		.gt_threshold (r_ff.gt_threshold),
		.lt_threshold (r_ff.lt_threshold),
		.conv_done    (CONV_DONE),
		.conv_data    (CONV_DATA),
		.conv_go      (seq_go),
		.busy         (seq_busy),
		.done         (seq_done),
		.hit          (seq_hit),
		.result       (seq_result)
	);

	always_comb
	begin
		nxt_r          = r_ff;
		nxt_r.ack      = req;
		nxt_r.sw_start = 1'b0;
		nxt_r.pin_sync = {r_ff.pin_sync[1:0], EXT_CONVERT_START};

		// read data, registered with the ack
		if (rd)
		begin
			nxt_r.rdata = 32'h0000_0000;
			if (addr_ok)
			begin
				unique case (idx)
					`IDX_INPUT_SELECT:
						nxt_r.rdata[4:0] = r_ff.input_select;
					`IDX_CONTROL:
					begin
						nxt_r.rdata[`CTL_EXT_EN]  = r_ff.ext_en;
						nxt_r.rdata[`CTL_OUTSIDE] = r_ff.outside;
					end
					`IDX_RESULT:
						nxt_r.rdata[9:0] = seq_result;
					`IDX_GT_THRESHOLD:
						nxt_r.rdata[9:0] = r_ff.gt_threshold;
					`IDX_LT_THRESHOLD:
						nxt_r.rdata[9:0] = r_ff.lt_threshold;
					`IDX_STATUS:
					begin
						nxt_r.rdata[1:0]       = r_ff.status;
						nxt_r.rdata[`ST_BUSY] = seq_busy;
					end
					`IDX_MASK:
						nxt_r.rdata[1:0] = r_ff.mask;
					default:
						nxt_r.rdata = 32'h0000_0000;
				endcase
			end
			// read of status clears it; events below still win
			if (addr_ok && idx == `IDX_STATUS)
				nxt_r.status = 2'b00;
		end

		if (wr && addr_ok)
		begin
			unique case (idx)
				`IDX_INPUT_SELECT:
					if (WB_SEL_I[0])
						nxt_r.input_select = WB_DAT_I[4:0];
				`IDX_CONTROL:
					if (WB_SEL_I[0])
					begin
						nxt_r.sw_start = WB_DAT_I[`CTL_SW_START];
						nxt_r.ext_en   = WB_DAT_I[`CTL_EXT_EN];
						nxt_r.outside  = WB_DAT_I[`CTL_OUTSIDE];
					end
				`IDX_GT_THRESHOLD:
					nxt_r.gt_threshold = gt_merge;
				`IDX_LT_THRESHOLD:
					nxt_r.lt_threshold = lt_merge;
				`IDX_MASK:
					if (WB_SEL_I[0])
						nxt_r.mask = WB_DAT_I[1:0];
				default:
					nxt_r.ack = req;
			endcase
		end

		// hardware sets after any clear so a same-cycle event is kept
		if (seq_hit)
			nxt_r.status[`ST_WINDOW] = 1'b1;
		if (seq_done)
			nxt_r.status[`ST_CONV_DONE] = 1'b1;
		nxt_r.irq = |(nxt_r.status & r_ff.mask);

		// mux decode, registered so the analog side sees clean levels
		nxt_r.port0_sel  = 8'h00;
		nxt_r.port1_sel  = 8'h00;
		nxt_r.temp_sel   = 1'b0;
		nxt_r.supply_sel = 1'b0;
		if (nxt_r.input_select[4] == 1'b0)
		begin
			if (nxt_r.input_select[3] == 1'b0)
				nxt_r.port0_sel = onehot8(nxt_r.input_select[2:0]);
			else
				nxt_r.port1_sel = onehot8(nxt_r.input_select[2:0]);
		end
		else if (nxt_r.input_select == `SEL_TEMP_SENSOR)
			nxt_r.temp_sel = 1'b1;
		else if (nxt_r.input_select == `SEL_SUPPLY)
			nxt_r.supply_sel = 1'b1;
		// codes from 5'h12 up select nothing on this part
	end

	always_ff @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			r_ff              <= '0;
			r_ff.input_select <= `RST_INPUT_SELECT;
			r_ff.gt_threshold <= `RST_THRESHOLD;
			r_ff.lt_threshold <= `RST_THRESHOLD;
		end
		else
			r_ff <= nxt_r;
	end

	assign WB_ACK_O      = r_ff.ack;
	assign WB_DAT_O      = r_ff.rdata;
	assign CONV_START    = seq_go;
	assign MUX_SELECT    = r_ff.input_select;
	assign PORT0_SELECT  = r_ff.port0_sel;
	assign PORT1_SELECT  = r_ff.port1_sel;
	assign TEMP_SELECT   = r_ff.temp_sel;
	assign SUPPLY_SELECT = r_ff.supply_sel;
	assign IRQ           = r_ff.irq;

endmodule : adc_input_select_window_compare

// ===== testbench/adc_win_chk.sv
module adc_win_chk
	import adc_ctl_pkg::*;
(
	// clock, reset and bus
	input wire logic        CLK,
	input wire logic        RESETN,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_WE_I,
	input wire logic [11:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        WB_ACK_O,
	// converter and mux
	input wire logic        CONV_START,
	input wire logic [4:0]  MUX_SELECT,
	input wire logic [7:0]  PORT0_SELECT,
	input wire logic [7:0]  PORT1_SELECT,
	input wire logic        TEMP_SELECT,
	input wire logic        SUPPLY_SELECT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	property p_ack_one;
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	property p_ack_resp;
		WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
	endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("no ack one cycle after request");
	property p_conv_one;
		CONV_START |=> !CONV_START;
	endproperty
	a_conv_one: assert property (p_conv_one) else $error("start pulse too long");
	property p_sel_rd;
		WB_ACK_O && $past(!WB_WE_I && WB_ADR_I == 12'h2EC) |-> WB_DAT_O[31:5] == '0;
	endproperty
	a_sel_rd: assert property (p_sel_rd) else $error("select upper bits not zero");
	// one-hot is registered with the select copy, so the two must always agree
	property p_port0;
		PORT0_SELECT == (MUX_SELECT[4:3] == 2'b00 ? 8'h01 << MUX_SELECT[2:0] : 8'h00);
	endproperty
	a_port0: assert property (p_port0) else $error("port 0 select wrong");
	property p_port1;
		PORT1_SELECT == (MUX_SELECT[4:3] == 2'b01 ? 8'h01 << MUX_SELECT[2:0] : 8'h00);
	endproperty
	a_port1: assert property (p_port1) else $error("port 1 select wrong");
	property p_temp;
		TEMP_SELECT == (MUX_SELECT == 5'h10);
	endproperty
	a_temp: assert property (p_temp) else $error("temperature select wrong");
	property p_supply;
		SUPPLY_SELECT == (MUX_SELECT == 5'h11);
	endproperty
	a_supply: assert property (p_supply) else $error("supply select wrong");
endmodule : adc_win_chk

bind adc_input_select_window_compare adc_win_chk u_chk (.CLK, .RESETN, .WB_CYC_I, .WB_STB_I,
	.WB_WE_I, .WB_ADR_I, .WB_DAT_O, .WB_ACK_O, .CONV_START, .MUX_SELECT, .PORT0_SELECT,
	.PORT1_SELECT, .TEMP_SELECT, .SUPPLY_SELECT);

// ===== testbench/conv_model.sv
module conv_model
	import adc_ctl_pkg::*;
(
	input wire logic       clk,
	input wire logic       start,
	input wire logic [9:0] val,
	input wire logic [4:0] lat,
	output logic           done,
	output logic [9:0]     data
);
	timeunit 1ns;
	timeprecision 1ps;
	// one process owns both outputs; a start seen while converting is not queued
	initial
	begin
		done = 1'b0;
		data = 10'h3FF;
		forever
		begin
			@(posedge clk);
			if (start === 1'b1)
			begin
				repeat (lat) @(posedge clk);
				done <= 1'b1;
				data <= val;
				@(posedge clk);
				done <= 1'b0;
				// data not held past the strobe
				data <= ~val;
			end
		end
	end
endmodule : conv_model

// ===== testbench/adc_input_select_window_compare_tb.sv
module adc_input_select_window_compare_tb import adc_ctl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, ext = 0;
	logic        ack, cdone, cstart, irq, hit;
	logic [11:0] adr = '0;
	logic [31:0] wdat = '0, rdat, r;
	logic [9:0]  cdata, v, cval = '0;
	logic [4:0]  clat = 5'h01;
	logic [32:0] q[$], e;
	logic [9:0]  vt[7] = '{10'h000, 10'h040, 10'h041, 10'h07F, 10'h080, 10'h081, 10'h3FF};
	int          n_fail = 0, cmp_count = 0, c, m, k;
	always #4 clk = ~clk;

	adc_input_select_window_compare dut (.CLK(clk), .RESETN(resetn), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .CONV_DONE(cdone), .CONV_DATA(cdata),
		.CONV_START(cstart), .MUX_SELECT(), .PORT0_SELECT(), .PORT1_SELECT(),
		.TEMP_SELECT(), .SUPPLY_SELECT(), .EXT_CONVERT_START(ext), .IRQ(irq));
	conv_model cm (.clk(clk), .start(cstart), .val(cval), .lat(clat), .done(cdone), .data(cdata));

	task finish_test;
		$display("mismatches %0d comparisons %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	task fail(input string s);
		n_fail++;
		$display("CHECK FAILED %0t %s", $time, s);
	endtask : fail

	// reads carry their expected data in d
	task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		q.push_back({~w, d});
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		i = 0;
		do
			@(posedge clk);
		while (ack !== 1'b1 && i++ < 64);
		if (ack !== 1'b1)
		begin
			fail("bus timeout");
			finish_test;
		end
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task wait_conv;
		int i;
		i = 0;
		while (cdone !== 1'b1 && i++ < 200)
			@(posedge clk);
		if (cdone !== 1'b1)
		begin
			fail("conversion timeout");
			finish_test;
		end
		repeat (4) @(posedge clk);
	endtask : wait_conv

	always @(posedge clk)
	begin
		if (ack === 1'b1 && q.size() > 0)
		begin
			e = q.pop_front();
			if (e[32])
			begin
				cmp_count++;
				if (rdat !== e[31:0])
					fail("read data mismatch");
			end
		end
	end

	initial
	begin
		r = $urandom(13);
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		wb(1'b0, 12'h2EC, 32'h0000_001F);
		for (c = 0; c < 32; c++)
		begin
			r = $urandom;
			wb(1'b1, 12'h2EC, {r[31:5], 5'(c)});
			wb(1'b0, 12'h2EC, {27'h000_0000, 5'(c)});
		end
		wb(1'b0, 12'h3FC, 32'h0000_0000);
		wb(1'b1, 12'h2F8, 32'h0000_0040);
		wb(1'b1, 12'h2FC, 32'h0000_0080);
		for (m = 0; m < 2; m++)
			for (k = 0; k < 8; k++)
			begin
				v = k < 7 ? vt[k] : 10'($urandom);
				hit = m ? (v < 10'h040 || v > 10'h080) : (v > 10'h040 && v < 10'h080);
				cval <= v;
				clat <= 5'($urandom_range(1, 20));
				// window events masked on both passes, done unmasked on the outside pass only
				wb(1'b1, 12'h304, {30'h0000_0000, 1'(m), 1'b0});
				cmp_count++;
				if (irq !== 1'b0)
					fail("irq not cleared by status read");
				wb(1'b1, 12'h2F0, {29'h0000_0000, 1'(m), 2'b01});
				wait_conv;
				cmp_count++;
				if (irq !== 1'(m))
					fail("irq level wrong");
				wb(1'b0, 12'h2F4, {22'h00_0000, v});
				wb(1'b0, 12'h300, {29'h0000_0000, 2'b01, hit});
			end
		wb(1'b1, 12'h2F0, 32'h0000_0002);
		cval <= 10'h155;
		ext <= 1'b1;
		wait_conv;
		wb(1'b0, 12'h2F4, 32'h0000_0155);
		finish_test;
	end
endmodule : adc_input_select_window_compare_tb
